//--- verilog/msbp_map.svh
// msbp_map.svh: timing counts, density levels and fifo size for the modulator bitstream port
// assumes a 125 MHz system clock; the master clock arrives as a sampled pin
`ifndef MSBP_MAP_SVH
`define MSBP_MAP_SVH
`define MSBP_CLK_PERIOD_PS     32'd8000
`define MSBP_MCLK_PERIOD_NS    32'd488
`define MSBP_BIT_PERIOD_NS     32'd1953
`define MSBP_PD_TIMEOUT_US     32'd40
`define MSBP_PD_TIMEOUT_CYC    ((`MSBP_PD_TIMEOUT_US * 32'd1000000) / `MSBP_CLK_PERIOD_PS)
`define MSBP_DIV_RATIO         2'd3
`define MSBP_DENS_FS_POS       8'd86
`define MSBP_DENS_FS_NEG       8'd14
`define MSBP_DENS_MID          8'd50
`define MSBP_DENS_SPAN         8'd100
`define MSBP_FIFO_DEPTH        4
`define MSBP_FIFO_WIDTH        1
`endif

//--- verilog/msbp_pkg.sv
// msbp_pkg.sv: types shared by the modulator bitstream port
// assumes msbp_map.svh supplies the numbers
package msbp_pkg;
  typedef enum logic [1:0] {
    MSBP_ST_DOWN  = 2'b00,
    MSBP_ST_RUN   = 2'b01,
    MSBP_ST_ALIGN = 2'b10
  } msbp_state_t;
endpackage

//--- verilog/msbp_fifo.sv
// msbp_fifo.sv: small flip-flop fifo with valid/ready on both sides
// assumes one clock, asynchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module msbp_fifo #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 4
) (
  // clock and reset
  input  wire logic             clock_i,
  input  wire logic             rstn_i,
  // fill side
  input  wire logic [WIDTH-1:0] in_data_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  // drain side
  output logic [WIDTH-1:0]      out_data_o,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  // flush
  input  wire logic             flush_i
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;
  assign in_ready_o  = (count != (AW+1)'(DEPTH));
  assign out_valid_o = (count != '0);
  assign out_data_o  = mem[rd_ptr];

  ////////////////////////////////////////////////////////////////////////////
  genvar g;
  generate
    for (g = 0; g < DEPTH; g++) begin : g_entry
      always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
          mem[g] <= '0;
        end else if (push && wr_ptr == AW'(g)) begin
          mem[g] <= in_data_i;
        end
      end
    end
  endgenerate

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else if (flush_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= AW'(wr_ptr + 1'b1);
      end
      if (pop) begin
        rd_ptr <= AW'(rd_ptr + 1'b1);
      end
      count <= (AW+1)'(count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
    end
  end
endmodule
`default_nettype wire

//--- verilog/msbp_core.sv
// msbp_core.sv: digital side of a delta-sigma modulator: master clock and
// sync capture, clock-stop power-down, one-bit oversampled output stream
// assumes master clock and sync arrive as pins from the filter, sampled here
// Functional notes
// - sync is sampled on the falling master-clock edge only.
// - the first rising master-clock edge after a captured sync is the instant t0.
// - a stopped master clock puts the device into power-down by itself.
// - power-down is reached about 40 us after the master clock stops.
// - output bits run at 512 kbit/s, about 1953 ns each.
// - the ones density of the output stays between 14 and 85 percent.
// - a sync rising edge moves the conversion state machine to MSBP_ST_ALIGN at t0.
// - ones density encodes amplitude: 50 percent mid, 85 top, 14 bottom.
// - the sampling rate is the master clock divided by 4.
`include "msbp_map.svh"
`timescale 1ns/1ps
`default_nettype none
module msbp_core
  import msbp_pkg::*;
(
  // clock and reset
  input  wire logic       clock_i,
  input  wire logic       rstn_i,
  // link pins from the filter
  input  wire logic       mclk_i,
  input  wire logic       msync_i,
  // converted amplitude, signed, -128 neg full scale .. 127 pos full scale
  input  wire logic [7:0] level_i,
  // link pins to the filter
  output logic            mdata_o,
  // status
  output logic            power_down_o,
  output logic            t0_o,
  output logic            sample_o
);
  localparam logic [23:0] PD_CYC = 24'(`MSBP_PD_TIMEOUT_CYC);

  ////////////////////////////////////////////////////////////////////////////
  // three-stage pin synchronisers, change taken when stages two and three agree
  logic [2:0] mclk_sync;
  logic [2:0] msync_sync;
  logic       mclk_lvl;
  logic       msync_lvl;
  logic       mclk_rise;
  logic       mclk_fall;

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mclk_sync  <= 3'h0;
      msync_sync <= 3'h0;
    end else begin
      mclk_sync  <= {mclk_sync[1:0], mclk_i};
      msync_sync <= {msync_sync[1:0], msync_i};
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mclk_lvl  <= 1'b0;
      msync_lvl <= 1'b0;
    end else begin
      if (mclk_sync[1] == mclk_sync[2]) begin
        mclk_lvl <= mclk_sync[2];
      end
      if (msync_sync[1] == msync_sync[2]) begin
        msync_lvl <= msync_sync[2];
      end
    end
  end

  assign mclk_rise = (mclk_sync[1] == mclk_sync[2]) && mclk_sync[2] && !mclk_lvl;
  assign mclk_fall = (mclk_sync[1] == mclk_sync[2]) && !mclk_sync[2] && mclk_lvl;

  ////////////////////////////////////////////////////////////////////////////
  // sync capture: looked at only on falling master-clock edges
  logic msync_prev;
  logic sync_pend;

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      msync_prev <= 1'b0;
      sync_pend  <= 1'b0;
    end else if (mclk_fall) begin
      msync_prev <= msync_lvl;
      if (msync_lvl && !msync_prev) begin
        sync_pend <= 1'b1;
      end
    end else if (mclk_rise) begin
      sync_pend <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // clock-stop watchdog; counts system clocks since the last master-clock edge
  logic [23:0] idle_cnt;
  logic        stopped;

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      idle_cnt <= 24'h000000;
    end else if (mclk_rise || mclk_fall) begin
      idle_cnt <= 24'h000000;
    end else if (idle_cnt != PD_CYC) begin
      idle_cnt <= 24'(idle_cnt + 24'h000001);
    end
  end

  assign stopped = (idle_cnt == PD_CYC);

  ////////////////////////////////////////////////////////////////////////////
  // conversion state machine
  msbp_state_t state;
  msbp_state_t next_state;

  always_comb begin
    next_state = state;
    case (state)
      MSBP_ST_DOWN: begin
        if (mclk_rise) begin
          next_state = MSBP_ST_RUN;
        end
      end
      MSBP_ST_RUN, MSBP_ST_ALIGN: begin
        if (stopped) begin
          next_state = MSBP_ST_DOWN;
        end else if (mclk_rise) begin
          next_state = sync_pend ? MSBP_ST_ALIGN : MSBP_ST_RUN;
        end
      end
      default: begin
        next_state = MSBP_ST_DOWN;
      end
    endcase
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state <= MSBP_ST_DOWN;
    end else begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // divide by four from t0; phase 0 is the first rising edge of each sample
  logic [1:0] phase;
  logic       run;
  logic       tick;

  assign run  = (state != MSBP_ST_DOWN) && !stopped;
  assign tick = run && mclk_rise;

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      phase <= 2'h0;
    end else if (!run) begin
      phase <= 2'h0;
    end else if (mclk_rise) begin
      if (sync_pend) begin
        phase <= 2'h1;
      end else if (phase == `MSBP_DIV_RATIO) begin
        phase <= 2'h0;
      end else begin
        phase <= 2'(phase + 2'h1);
      end
    end
  end

  logic sample_now;
  assign sample_now = tick && (sync_pend || phase == 2'h0);

  ////////////////////////////////////////////////////////////////////////////
  // first-order density modulator; the level maps onto 14..85 percent ones
  // a first-order loop stands in for the real analog loop: it gives the same
  // mean density, not the noise shaping
  logic [7:0]  dens;
  logic [7:0]  acc;
  logic [8:0]  acc_sum;
  logic        bit_new;
  logic [15:0] scaled;

  assign scaled  = 16'($signed(level_i) * $signed(9'sd36));
  assign dens    = 8'(`MSBP_DENS_MID + 8'(16'($signed(scaled) >>> 7)));
  assign acc_sum = {1'b0, acc} + {1'b0, dens};
  assign bit_new = (acc_sum >= {1'b0, `MSBP_DENS_SPAN});

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      acc <= 8'h00;
    end else if (!run || (tick && sync_pend)) begin
      acc <= 8'h00;
    end else if (sample_now) begin
      acc <= bit_new ? 8'(acc_sum - {1'b0, `MSBP_DENS_SPAN}) : acc_sum[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output bits queue through the fifo; the drain pops once per sample period
  logic out_bit;
  logic out_valid;
  logic in_ready;

  msbp_fifo #(
    .WIDTH (`MSBP_FIFO_WIDTH),
    .DEPTH (`MSBP_FIFO_DEPTH)
  ) u_fifo (
    .clock_i     (clock_i),
    .rstn_i      (rstn_i),
    .in_data_i   (bit_new),
    .in_valid_i  (sample_now),
    .in_ready_o  (in_ready),
    .out_data_o  (out_bit),
    .out_valid_o (out_valid),
    .out_ready_i (sample_now),
    .flush_i     (!run || (tick && sync_pend))
  );

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mdata_o <= 1'b0;
    end else if (!run) begin
      mdata_o <= 1'b0;
    end else if (sample_now) begin
      mdata_o <= out_valid ? out_bit : bit_new;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status outputs
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      power_down_o <= 1'b1;
      t0_o         <= 1'b0;
      sample_o     <= 1'b0;
    end else begin
      power_down_o <= !run;
      t0_o         <= tick && sync_pend;
      sample_o     <= sample_now && in_ready;
    end
  end
endmodule
`default_nettype wire

//--- tb/msbp_core_monitor.sv
// msbp_core_monitor.sv: port assertions for msbp_core
// assumes mclk_i and msync_i are raw pins, seen before synchronising
`timescale 1ns/1ps
`default_nettype none
module msbp_core_monitor (
  // clock and reset
  input  wire logic       clock_i,
  input  wire logic       rstn_i,
  // link and status
  input  wire logic       mclk_i,
  input  wire logic       msync_i,
  input  wire logic [7:0] level_i,
  input  wire logic       mdata_o,
  input  wire logic       power_down_o,
  input  wire logic       t0_o,
  input  wire logic       sample_o
);
  logic        mq;
  logic        f1;
  logic        f2;
  logic        arm;
  logic [2:0]  rises;
  logic [12:0] idle;
  wire         rise = mclk_i && !mq;
  // sync level at the last two falls
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mq <= 1'b0;
      f1 <= 1'b0;
      f2 <= 1'b0;
    end else begin
      mq <= mclk_i;
      if (!mclk_i && mq) begin
        f1 <= msync_i;
        f2 <= f1;
      end
    end
  end
  // rise count per bit; idle saturates so the timeout stays visible
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rises <= 3'h0;
      idle  <= 13'h0;
      arm   <= 1'b0;
    end else begin
      if (sample_o) rises <= {2'h0, rise};
      else if (rise && rises != 3'h7) rises <= rises + 3'h1;
      idle <= (mclk_i != mq) ? 13'h0 : ((idle == 13'h1FFF) ? idle : idle + 13'h1);
      arm  <= power_down_o ? 1'b0 : (sample_o | arm);
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge clock_i);
  endclocking
  default disable iff (!rstn_i);
  sequence s_new_sync;
    f1 && !f2;
  endsequence
  sequence s_sync_rise;
    rise && f1 && !f2;
  endsequence
  property p_t0_cause;   t0_o |-> s_new_sync; endproperty
  property p_t0_follow;  s_sync_rise |-> ##[1:8] t0_o; endproperty
  property p_t0_bit;     t0_o |-> sample_o ##1 !t0_o; endproperty
  property p_bit_len;    sample_o && arm && !t0_o |-> rises == 3'h4; endproperty
  property p_hold;       !sample_o && !power_down_o |-> $stable(mdata_o); endproperty
  property p_pd_zero;    power_down_o && $past(power_down_o) |-> !mdata_o; endproperty
  property p_pd_late;    idle == 13'd5020 |-> power_down_o; endproperty
  property p_pd_early;   $rose(power_down_o) |-> idle > 13'd4990; endproperty
  property p_pd_exit;    $fell(power_down_o) |-> idle < 13'd12; endproperty
  a_t0_cause:  assert property (p_t0_cause) else $error("t0 without sync at a fall");
  a_t0_follow: assert property (p_t0_follow) else $error("t0 missing after sync");
  a_t0_bit:    assert property (p_t0_bit) else $error("t0 without fresh bit");
  a_bit_len:   assert property (p_bit_len) else $error("bit not four mclk long");
  a_hold:      assert property (p_hold) else $error("bit changed between samples");
  a_pd_zero:   assert property (p_pd_zero) else $error("data high in power down");
  a_pd_late:   assert property (p_pd_late) else $error("power down too late");
  a_pd_early:  assert property (p_pd_early) else $error("power down too early");
  a_pd_exit:   assert property (p_pd_exit) else $error("power up without mclk");
endmodule
bind msbp_core msbp_core_monitor u_mon (.clock_i(clock_i), .rstn_i(rstn_i), .mclk_i(mclk_i),
  .msync_i(msync_i), .level_i(level_i), .mdata_o(mdata_o), .power_down_o(power_down_o),
  .t0_o(t0_o), .sample_o(sample_o));
`default_nettype wire

//--- tb/msbp_filter_model.sv
// msbp_filter_model.sv: far-end filter: master clock, sync, ones tally
// assumes nothing; mclk rests low while run_i is low
`timescale 1ns/1ps
`default_nettype none
module msbp_filter_model (
  input  wire logic run_i,
  input  wire logic mdata_i,
  output logic      mclk_o,
  output logic      msync_o
);
  int ones = 0;
  int bits = 0;
  // decimated result of a ones tally; clamped to the full-scale span
  localparam logic [23:0] FS_POS = 24'h5D1420;
  localparam logic [23:0] FS_NEG = 24'hA2EBE0;
  function automatic logic [23:0] code24(input int n_one, input int n_all);
    longint fs;
    longint v;
    fs = longint'(FS_POS);
    v = ((longint'(n_one) * 100) - (longint'(n_all) * 50)) * fs / (longint'(n_all) * 36);
    if (v > fs) return FS_POS;
    if (v < -fs) return FS_NEG;
    return 24'(v);
  endfunction
  initial begin
    mclk_o = 1'b0;
    msync_o = 1'b0;
  end
  always begin
    wait (run_i);
    #244 mclk_o = 1'b1;
    #244 mclk_o = 1'b0;
  end
  // every mclk tallied; bits last four mclk, so the ratio is unchanged
  always @(posedge mclk_o) begin
    ones = ones + mdata_i;
    bits = bits + 1;
  end
  // late puts the pulse around a rise only, missing every fall
  task automatic sync(input bit late);
    @(posedge mclk_o);
    if (late) begin
      @(negedge mclk_o);
      #40 msync_o = 1'b1;
      #248 msync_o = 1'b0;
    end else begin
      #122 msync_o = 1'b1;
      @(negedge mclk_o);
      #122 msync_o = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

//--- tb/msbp_core_test.sv
// msbp_core_test.sv: self-checking bench for msbp_core
// assumes the filter model drives the link pins
`timescale 1ns/1ps
`default_nettype none
module msbp_core_test;
  typedef struct {logic [7:0] lvl; int lo; int hi;} msbp_row_t;
  logic      clock_i = 1'b0;
  logic      rstn_i = 1'b0;
  logic      run = 1'b0;
  logic [7:0] level_i = 8'h00;
  logic      mclk_i;
  logic      msync_i;
  logic      mdata_o;
  logic      power_down_o;
  logic      t0_o;
  logic      sample_o;
  logic      seen;
  int        err_count = 0;
  int        n_checks = 0;
  int        cyc = 0;
  int        d;
  msbp_row_t rows[3] = '{'{8'h80, 10, 18}, '{8'h00, 46, 54}, '{8'h7F, 82, 90}};
  always #4 clock_i = ~clock_i;
  msbp_core u_dut (.clock_i(clock_i), .rstn_i(rstn_i), .mclk_i(mclk_i), .msync_i(msync_i),
    .level_i(level_i), .mdata_o(mdata_o), .power_down_o(power_down_o), .t0_o(t0_o), .sample_o(sample_o));
  msbp_filter_model u_far (.run_i(run), .mdata_i(mdata_o), .mclk_o(mclk_i), .msync_o(msync_i));
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [23:0] got, input logic [23:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // sampled on the falling edge, clear of the register updates
  task automatic wait_t0(output logic s);
    s = 1'b0;
    repeat (200) @(negedge clock_i) if (t0_o === 1'b1) s = 1'b1;
  endtask
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 80000) begin
      err_count++;
      give_verdict;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge clock_i);
    check({mdata_o, power_down_o, t0_o, sample_o}, 4'h4);
    #1 rstn_i = 1'b1;
    repeat (20) @(negedge clock_i);
    check(power_down_o, 1'b1);
    run = 1'b1;
    $display("reset test done");
    foreach (rows[i]) begin
      @(posedge clock_i) #1 level_i = rows[i].lvl;
      u_far.bits = 0;
      wait (u_far.bits >= 40);
      u_far.ones = 0;
      u_far.bits = 0;
      wait (u_far.bits == 240);
      d = u_far.ones * 100 / 240;
      check(d >= rows[i].lo && d <= rows[i].hi, 1'b1);
      $display("density row %0d done: %0d", i, d);
    end
    check(u_far.code24(86, 100), 24'h5D1420);
    check(u_far.code24(14, 100), 24'hA2EBE0);
    check(u_far.code24(50, 100), 24'h000000);
    $display("code test done");
    u_far.sync(1'b0);
    wait_t0(seen);
    check(seen, 1'b1);
    u_far.sync(1'b1);
    wait_t0(seen);
    check(seen, 1'b0);
    $display("sync test done");
    run = 1'b0;
    repeat (5100) @(negedge clock_i);
    check({power_down_o, mdata_o}, 4'h2);
    run = 1'b1;
    repeat (200) @(negedge clock_i);
    check(power_down_o, 1'b0);
    $display("power down test done");
    @(posedge clock_i) #1 rstn_i = 1'b0;
    repeat (2) @(negedge clock_i);
    check({mdata_o, power_down_o, t0_o, sample_o}, 4'h4);
    @(posedge clock_i) #1 rstn_i = 1'b1;
    repeat (2) @(negedge clock_i);
    check({mdata_o, power_down_o, t0_o, sample_o}, 4'h4);
    repeat (600) @(posedge clock_i);
    check(power_down_o, 1'b0);
    d = 0;
    repeat (976) @(negedge clock_i) if (sample_o === 1'b1) d++;
    check(24'(d), 24'd4);
    $display("second reset test done");
    give_verdict;
  end
endmodule
`default_nettype wire
